// ---- hw/fru_ieee_remainder_unit.sv ----
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module fru_ieee_remainder_unit (
  input wire logic I_CORE_CLK,
  input wire logic I_RESET_N,
  input wire logic [7:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  output logic O_BUSY
);
  // =====================================================
  // helpers
  function automatic logic [6:0] lzc(input logic [63:0] v);
    logic [6:0] c;
    logic found;
    c = 7'h00;
    found = 1'b0;
    for (int i = 63; i >= 0; i--) begin
      if (!found && v[i]) begin
        found = 1'b1;
      end else if (!found) begin
        c = c + 7'h01;
      end
    end
    return c;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_nan(input fru_pkg::fru_ext_t v);
    return (v.exp == fru_pkg::EXP_MAX) && (v.mant[62:0] != 63'h0);
  endfunction

  function automatic logic is_inf(input fru_pkg::fru_ext_t v);
    return (v.exp == fru_pkg::EXP_MAX) && (v.mant[62:0] == 63'h0);
  endfunction

  function automatic logic is_zero(input fru_pkg::fru_ext_t v);
    return (v.exp == 15'h0000) && (v.mant == 64'h0);
  endfunction

  // denormal single/double inputs are flushed to zero to keep the converter small
  function automatic fru_pkg::fru_ext_t to_ext(input logic [2:0] fmt, input logic [31:0] w0,
                                               input logic [31:0] w1, input logic [31:0] w2);
    fru_pkg::fru_ext_t r;
    logic [31:0] iv;
    logic [31:0] mag;
    logic [6:0] l;
    r = '0;
    iv = w0;
    l = 7'h00;
    if (fmt == fru_pkg::FMT_WORD) begin
      iv = {{16{w0[15]}}, w0[15:0]};
    end else if (fmt == fru_pkg::FMT_BYTE) begin
      iv = {{24{w0[7]}}, w0[7:0]};
    end
    mag = iv[31] ? (32'h0 - iv) : iv;
    case (fmt)
      fru_pkg::FMT_SINGLE: begin
        r.sign = w0[31];
        if (w0[30:23] == 8'hff) begin
          r.exp = fru_pkg::EXP_MAX;
          r.mant = {1'b1, w0[22:0], 40'h0};
        end else if (w0[30:23] != 8'h00) begin
          r.exp = {7'h00, w0[30:23]} + fru_pkg::SGL_ADJ;
          r.mant = {1'b1, w0[22:0], 40'h0};
        end
      end
      fru_pkg::FMT_DOUBLE: begin
        r.sign = w0[31];
        if (w0[30:20] == 11'h7ff) begin
          r.exp = fru_pkg::EXP_MAX;
          r.mant = {1'b1, w0[19:0], w1, 11'h0};
        end else if (w0[30:20] != 11'h000) begin
          r.exp = {4'h0, w0[30:20]} + fru_pkg::DBL_ADJ;
          r.mant = {1'b1, w0[19:0], w1, 11'h0};
        end
      end
      fru_pkg::FMT_EXT: begin
        r = {w0[31], w0[30:16], w1, w2};
      end
      default: begin
        r.sign = iv[31];
        if (mag != 32'h0) begin
          l = lzc({mag, 32'h0});
          r.mant = {mag, 32'h0} << l;
          r.exp = fru_pkg::INT_EXP - {8'h00, l};
        end
      end
    endcase
    return r;
  endfunction

  // =====================================================
  // state
  fru_pkg::fru_st_t s_reg;
  fru_pkg::fru_st_t s_next;
  fru_pkg::fru_ext_t x;
  fru_pkg::fru_ext_t y;
  fru_pkg::fru_ext_t res;
  logic acc;
  logic rm;
  logic ea_ok;
  logic wr_res;
  logic up;
  logic up2;
  logic sg;
  logic [2:0] mode;
  logic [2:0] rg;
  logic [2:0] fmt;
  logic [2:0] fi;
  logic [31:0] fw;
  logic [65:0] rem_f;
  logic [6:0] q_f;
  logic [66:0] r2;
  logic [63:0] m;
  logic [63:0] lowm;
  logic [63:0] lost;
  logic [63:0] half;
  logic [64:0] sum;
  logic [16:0] e;
  logic [16:0] lim;
  logic [6:0] lz;

  assign O_AVS_READDATA = s_reg.rdata;
  assign O_AVS_WAITREQUEST = s_reg.waitreq;
  assign O_BUSY = s_reg.busy;

  always_comb begin
    s_next = s_reg;
    s_next.waitreq = 1'b1;
    x = s_reg.fpr[s_reg.extword[9:7]];
    rm = s_reg.extword[14];
    fmt = s_reg.extword[12:10];
    mode = s_reg.opword[5:3];
    rg = s_reg.opword[2:0];
    y = rm ? to_ext(fmt, s_reg.opnd0, s_reg.opnd1, s_reg.opnd2) : s_reg.fpr[fmt];
    res = '0;
    wr_res = 1'b0;
    ea_ok = 1'b1;
    up = 1'b0;
    up2 = 1'b0;
    sg = s_reg.rsign;
    rem_f = s_reg.rem;
    q_f = s_reg.q;
    r2 = '0;
    m = '0;
    lowm = '0;
    lost = '0;
    half = '0;
    sum = '0;
    e = '0;
    lz = '0;
    lim = fru_pkg::LIM_EXT;
    fi = I_AVS_ADDRESS[6:4];
    fw = 32'h0;
    case (I_AVS_ADDRESS[3:2])
      2'h0: fw = {s_reg.fpr[fi].sign, s_reg.fpr[fi].exp, 16'h0};
      2'h1: fw = s_reg.fpr[fi].mant[63:32];
      2'h2: fw = s_reg.fpr[fi].mant[31:0];
      default: fw = 32'h0;
    endcase
    // =====================================================
    // bus slave: one wait cycle, stalled while an operation runs
    acc = (I_AVS_READ || I_AVS_WRITE) && !s_reg.busy && s_reg.waitreq;
    if (acc) begin
      s_next.waitreq = 1'b0;
      s_next.rdata = 32'h0;
      if (I_AVS_ADDRESS[fru_pkg::FPR_SEL_BIT]) begin
        s_next.rdata = fw;
      end else begin
        case ({I_AVS_ADDRESS[7:2], 2'h0})
          fru_pkg::ADDR_CMD: s_next.rdata = {s_reg.opword, s_reg.extword};
          fru_pkg::ADDR_STATUS: begin
            s_next.rdata[fru_pkg::ST_QUO_LSB +: 8] = s_reg.quo;
            s_next.rdata[fru_pkg::ST_EXC_LSB +: 8] = s_reg.exc;
            s_next.rdata[fru_pkg::ST_UNSUP_BIT] = s_reg.unsup;
            s_next.rdata[fru_pkg::ST_ILLEGAL_BIT] = s_reg.illegal;
            s_next.rdata[fru_pkg::ST_BUSY_BIT] = s_reg.busy;
          end
          fru_pkg::ADDR_CTRL: s_next.rdata = {30'h0, s_reg.prec};
          fru_pkg::ADDR_OPND0: s_next.rdata = s_reg.opnd0;
          fru_pkg::ADDR_OPND1: s_next.rdata = s_reg.opnd1;
          fru_pkg::ADDR_OPND2: s_next.rdata = s_reg.opnd2;
          default: s_next.rdata = 32'h0;
        endcase
      end
      if (I_AVS_WRITE) begin
        s_next.rdata = 32'h0;
        fw = merge(fw, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
        if (I_AVS_ADDRESS[fru_pkg::FPR_SEL_BIT]) begin
          case (I_AVS_ADDRESS[3:2])
            2'h0: s_next.fpr[fi] = {fw[31], fw[30:16], s_reg.fpr[fi].mant};
            2'h1: s_next.fpr[fi].mant[63:32] = fw;
            2'h2: s_next.fpr[fi].mant[31:0] = fw;
            default: s_next.fpr[fi] = s_reg.fpr[fi];
          endcase
        end else begin
          case ({I_AVS_ADDRESS[7:2], 2'h0})
            fru_pkg::ADDR_CMD: begin
              fw = merge({s_reg.opword, s_reg.extword}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
              s_next.opword = fw[31:16];
              s_next.extword = fw[15:0];
              s_next.state = fru_pkg::ST_PREP;
              s_next.busy = 1'b1;
              s_next.illegal = 1'b0;
              s_next.unsup = 1'b0;
            end
            fru_pkg::ADDR_CTRL: begin
              fw = merge({30'h0, s_reg.prec}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
              s_next.prec = fw[1:0];
            end
            fru_pkg::ADDR_OPND0: s_next.opnd0 = merge(s_reg.opnd0, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
            fru_pkg::ADDR_OPND1: s_next.opnd1 = merge(s_reg.opnd1, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
            fru_pkg::ADDR_OPND2: s_next.opnd2 = merge(s_reg.opnd2, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
            default: s_next.prec = s_reg.prec;
          endcase
        end
      end
    end
    // =====================================================
    // decode and datapath
    case (s_reg.state)
      fru_pkg::ST_PREP: begin
        s_next.state = fru_pkg::ST_IDLE;
        s_next.busy = 1'b0;
        if (rm && (mode == fru_pkg::EA_AREG || (mode == fru_pkg::EA_SPECIAL && rg > fru_pkg::EA_REG_IMM))) begin
          ea_ok = 1'b0;
        end
        // register direct for short formats only
        if (rm && mode == fru_pkg::EA_DREG && !(fmt == fru_pkg::FMT_LONG || fmt == fru_pkg::FMT_SINGLE
            || fmt == fru_pkg::FMT_WORD || fmt == fru_pkg::FMT_BYTE)) begin
          ea_ok = 1'b0;
        end
        if (rm && fmt == 3'h7) begin
          ea_ok = 1'b0;
        end
        // foreign id is silently left alone
        if (s_reg.opword[15:12] != fru_pkg::COP_LINE || s_reg.opword[11:9] != fru_pkg::FPU_CP_ID) begin
          s_next.state = fru_pkg::ST_IDLE;
        // never-true branch, so no-operation needs no opcode of its own
        end else if (s_reg.opword[8:7] == fru_pkg::BR_FAMILY) begin
          s_next.illegal = (s_reg.opword[5:0] != fru_pkg::COND_NEVER);
        // general op word and remainder opmode
        end else if (s_reg.opword[8:6] != fru_pkg::GEN_TYPE || s_reg.extword[15]
                     || s_reg.extword[13] || s_reg.extword[6:0] != fru_pkg::OPMODE_REM || !ea_ok) begin
          s_next.illegal = 1'b1;
        // packed decimal goes to software, not converted here
        end else if (rm && fmt == fru_pkg::FMT_PACKED) begin
          s_next.unsup = 1'b1;
        end else begin
          s_next.exc = 8'h00;
          s_next.quo = {x.sign ^ y.sign, 7'h00};
          s_next.q = 7'h00;
          s_next.rsign = x.sign;
          s_next.fix = 1'b0;
          s_next.busy = 1'b1;
          s_next.state = fru_pkg::ST_DONE;
          if (is_nan(x) || is_nan(y)) begin
            res = is_nan(x) ? x : y;
            res.mant[fru_pkg::QNAN_BIT] = 1'b1;
            s_next.exc[fru_pkg::EXC_SIGNALLING_NAN_FLAG] = !(is_nan(x) ? x.mant[62] : y.mant[62]);
            wr_res = 1'b1;
          end else if (is_zero(y) || is_inf(x)) begin
            res = {1'b0, fru_pkg::EXP_MAX, fru_pkg::NAN_MANT};
            s_next.exc[fru_pkg::EXC_OPERAND_ERROR_FLAG] = 1'b1;
            wr_res = 1'b1;
          end else if (is_zero(x)) begin
            res = x;
            wr_res = 1'b1;
          // infinite modulus keeps old value, still rounded
          end else if (is_inf(y) || {2'h0, x.exp} + 17'h1 < {2'h0, y.exp}) begin
            s_next.rem = {2'h0, x.mant};
            s_next.rexp = {2'h0, x.exp};
          end else begin
            s_next.fix = 1'b1;
            s_next.state = fru_pkg::ST_DIV;
            s_next.rem = {2'h0, x.mant};
            if (x.exp >= y.exp) begin
              s_next.div = {2'h0, y.mant};
              s_next.rexp = {2'h0, y.exp};
              s_next.cnt = x.exp - y.exp;
            end else begin
              s_next.div = {1'b0, y.mant, 1'b0};
              s_next.rexp = {2'h0, x.exp};
              s_next.cnt = 15'h0000;
            end
          end
          if (wr_res) begin
            s_next.state = fru_pkg::ST_IDLE;
            s_next.busy = 1'b0;
          end
        end
      end
      // one quotient bit per cycle; long exponent gaps take many cycles
      fru_pkg::ST_DIV: begin
        up = (s_reg.rem >= s_reg.div);
        rem_f = up ? (s_reg.rem - s_reg.div) : s_reg.rem;
        s_next.q = {s_reg.q[5:0], up};
        if (s_reg.cnt == 15'h0000) begin
          s_next.rem = rem_f;
          s_next.state = fru_pkg::ST_DONE;
        end else begin
          s_next.rem = {rem_f[64:0], 1'b0};
          s_next.cnt = s_reg.cnt - 15'h0001;
        end
      end
      fru_pkg::ST_DONE: begin
        r2 = {s_reg.rem, 1'b0};
        if (s_reg.fix && (r2 > {1'b0, s_reg.div} || (r2 == {1'b0, s_reg.div} && s_reg.q[0]))) begin
          rem_f = s_reg.div - s_reg.rem;
          q_f = s_reg.q + 7'h01;
          sg = ~s_reg.rsign;
        end
        s_next.quo[6:0] = q_f;
        if (rem_f[64]) begin
          m = rem_f[64:1];
          e = s_reg.rexp + 17'h00001;
        end else begin
          lz = lzc(rem_f[63:0]);
          m = rem_f[63:0] << lz;
          e = s_reg.rexp - {10'h000, lz};
        end
        // termination rounding at the chosen precision
        if (s_reg.prec == fru_pkg::PREC_SINGLE) begin
          lowm = fru_pkg::LOW_SINGLE;
          lim = fru_pkg::LIM_SINGLE;
        end else if (s_reg.prec == fru_pkg::PREC_DOUBLE) begin
          lowm = fru_pkg::LOW_DOUBLE;
          lim = fru_pkg::LIM_DOUBLE;
        end
        lost = m & lowm;
        half = lowm ^ (lowm >> 1);
        up2 = (lost > half) || (lost == half && ((m & (half << 1)) != 64'h0));
        sum = {1'b0, m & ~lowm} + (up2 ? {half, 1'b0} : 65'h0);
        m = sum[64] ? sum[64:1] : sum[63:0];
        e = sum[64] ? e + 17'h00001 : e;
        s_next.exc[fru_pkg::EXC_INEX_RES] = (lost != 64'h0);
        if (rem_f == 66'h0) begin
          res = {s_reg.rsign, 15'h0000, 64'h0};
          s_next.exc[fru_pkg::EXC_INEX_RES] = 1'b0;
        end else if (e[16] || e == 17'h0) begin
          res = {sg, 15'h0000, 64'h0};
          s_next.exc[fru_pkg::EXC_UNDERFLOW_FLAG] = 1'b1;
        end else if (e >= lim) begin
          res = {sg, fru_pkg::EXP_MAX, 64'h0};
          s_next.exc[fru_pkg::EXC_OVERFLOW_FLAG] = 1'b1;
        end else begin
          res = {sg, e[14:0], m};
        end
        wr_res = 1'b1;
        s_next.state = fru_pkg::ST_IDLE;
        s_next.busy = 1'b0;
      end
      // idle keeps what the bus side chose, so a command write still reaches prep
      fru_pkg::ST_IDLE: begin
      end
      default: s_next.state = fru_pkg::ST_IDLE;
    endcase
    // result back into the destination register
    if (wr_res) begin
      s_next.fpr[s_reg.extword[9:7]] = res;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      s_reg <= '0;
      s_reg.waitreq <= 1'b1;
      s_reg.prec <= fru_pkg::CTRL_RST;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule
`default_nettype wire

// ---- hw/fru_pkg.sv ----
package fru_pkg;
  // =====================================================
  // register map, byte addresses on the slave
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_OPND0 = 8'h0c;
  localparam logic [7:0] ADDR_OPND1 = 8'h10;
  localparam logic [7:0] ADDR_OPND2 = 8'h14;
  localparam int FPR_SEL_BIT = 7;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ILLEGAL_BIT = 1;
  localparam int ST_UNSUP_BIT = 2;
  localparam int ST_EXC_LSB = 8;
  localparam int ST_QUO_LSB = 16;
  localparam logic [1:0] CTRL_RST = 2'h0;
  // =====================================================
  // instruction encoding
  localparam logic [3:0] COP_LINE = 4'hf;
  localparam logic [2:0] FPU_CP_ID = 3'h1;
  localparam logic [1:0] BR_FAMILY = 2'h1;
  localparam logic [2:0] GEN_TYPE = 3'h0;
  localparam logic [5:0] COND_NEVER = 6'h00;
  localparam logic [6:0] OPMODE_REM = 7'h25;
  localparam logic [2:0] FMT_LONG = 3'h0;
  localparam logic [2:0] FMT_SINGLE = 3'h1;
  localparam logic [2:0] FMT_EXT = 3'h2;
  localparam logic [2:0] FMT_PACKED = 3'h3;
  localparam logic [2:0] FMT_WORD = 3'h4;
  localparam logic [2:0] FMT_DOUBLE = 3'h5;
  localparam logic [2:0] FMT_BYTE = 3'h6;
  localparam logic [2:0] EA_DREG = 3'h0;
  localparam logic [2:0] EA_AREG = 3'h1;
  localparam logic [2:0] EA_SPECIAL = 3'h7;
  localparam logic [2:0] EA_REG_IMM = 3'h4;
  // =====================================================
  // exception byte bit positions
  localparam int EXC_BRANCH_UNORD = 7;
  localparam int EXC_SIGNALLING_NAN_FLAG = 6;
  localparam int EXC_OPERAND_ERROR_FLAG = 5;
  localparam int EXC_OVERFLOW_FLAG = 4;
  localparam int EXC_UNDERFLOW_FLAG = 3;
  localparam int EXC_DZ = 2;
  localparam int EXC_INEX_RES = 1;
  localparam int EXC_INEX_DEC = 0;
  // =====================================================
  // number formats
  localparam logic [1:0] PREC_EXT = 2'h0;
  localparam logic [1:0] PREC_SINGLE = 2'h1;
  localparam logic [1:0] PREC_DOUBLE = 2'h2;
  localparam logic [63:0] LOW_SINGLE = 64'h0000_00ff_ffff_ffff;
  localparam logic [63:0] LOW_DOUBLE = 64'h0000_0000_0000_07ff;
  localparam logic [16:0] LIM_SINGLE = 17'h0407e;
  localparam logic [16:0] LIM_DOUBLE = 17'h043fe;
  localparam logic [16:0] LIM_EXT = 17'h07fff;
  localparam logic [14:0] EXP_MAX = 15'h7fff;
  localparam logic [14:0] INT_EXP = 15'h401e;
  localparam logic [14:0] SGL_ADJ = 15'h3f80;
  localparam logic [14:0] DBL_ADJ = 15'h3c00;
  localparam logic [63:0] NAN_MANT = 64'hffff_ffff_ffff_ffff;
  localparam int QNAN_BIT = 62;

  typedef struct packed {
    logic sign;
    logic [14:0] exp;
    logic [63:0] mant;
  } fru_ext_t;

  typedef enum logic [1:0] {ST_IDLE, ST_PREP, ST_DIV, ST_DONE} fru_state_t;

  typedef struct packed {
    fru_state_t state;
    logic busy;
    logic waitreq;
    logic [31:0] rdata;
    logic [15:0] opword;
    logic [15:0] extword;
    logic [1:0] prec;
    logic [7:0] quo;
    logic [7:0] exc;
    logic illegal;
    logic unsup;
    logic [31:0] opnd0;
    logic [31:0] opnd1;
    logic [31:0] opnd2;
    fru_ext_t [7:0] fpr;
    logic [65:0] rem;
    logic [65:0] div;
    logic [14:0] cnt;
    logic [6:0] q;
    logic rsign;
    logic fix;
    logic [16:0] rexp;
  } fru_st_t;
endpackage

// ---- verification/fru_rem_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========
// bus and status checker
module fru_rem_monitor (
  input wire logic I_CORE_CLK,
  input wire logic I_RESET_N,
  input wire logic [7:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  input wire logic [31:0] O_AVS_READDATA,
  input wire logic O_AVS_WAITREQUEST,
  input wire logic O_BUSY
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESET_N);
  wire logic ack = !O_AVS_WAITREQUEST;
  wire logic [5:0] wa = I_AVS_ADDRESS[7:2];
  wire logic st_rd = ack && I_AVS_READ && wa == fru_pkg::ADDR_STATUS[7:2];
  a_ack_one_cycle: assert property (ack |=> !ack) else $error("ack too long");
  a_ack_has_request: assert property ($fell(O_AVS_WAITREQUEST) |->
    $past(I_AVS_READ || I_AVS_WRITE)) else $error("ack without request");
  a_busy_refuses: assert property ($past(O_BUSY) |-> O_AVS_WAITREQUEST)
    else $error("access taken while busy");
  a_cmd_starts_op: assert property (ack && I_AVS_WRITE && wa == 6'h00 |-> O_BUSY)
    else $error("command did not start");
  a_write_reads_zero: assert property (ack && I_AVS_WRITE |-> O_AVS_READDATA == 32'h0)
    else $error("read data not zero on write");
  a_rdata_holds: assert property (!$stable(O_AVS_READDATA) |-> $fell(O_AVS_WAITREQUEST))
    else $error("read data moved outside ack");
  a_status_idle: assert property (st_rd |-> O_AVS_READDATA[0] == 1'b0)
    else $error("status read while busy");
  a_status_fields: assert property (st_rd |-> O_AVS_READDATA[31:24] == 8'h0 &&
    O_AVS_READDATA[7:3] == 5'h0) else $error("status spare bits set");
  a_exc_cleared: assert property (st_rd |-> !O_AVS_READDATA[15] &&
    !O_AVS_READDATA[10] && !O_AVS_READDATA[8]) else $error("cleared flag set");
endmodule
bind fru_ieee_remainder_unit fru_rem_monitor fru_rem_monitor_inst (
  .I_CORE_CLK(I_CORE_CLK), .I_RESET_N(I_RESET_N), .I_AVS_ADDRESS(I_AVS_ADDRESS),
  .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
  .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE), .O_AVS_READDATA(O_AVS_READDATA),
  .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_BUSY(O_BUSY));
`default_nettype wire

// ---- verification/fru_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========
// host side bus master
module fru_host_model (
  input wire logic i_clk,
  input wire logic i_waitreq,
  input wire logic [31:0] i_rdata,
  output logic [7:0] o_addr,
  output logic o_read,
  output logic o_write,
  output logic [31:0] o_wdata,
  output logic [3:0] o_be
);
  initial begin
    o_addr = 8'h0;
    o_read = 1'b0;
    o_write = 1'b0;
    o_wdata = 32'h0;
    o_be = 4'hf;
  end
  // released lines show the inverse so a stale value never passes
  task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output bit to);
    int n;
    n = 0;
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_write <= w;
    o_read <= !w;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_waitreq !== 1'b0 && n < 400);
    q = i_rdata;
    to = n >= 400;
    o_write <= 1'b0;
    o_read <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========
// remainder unit bench
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr;
  logic rd_en, wr_en, wrq, busy;
  logic [31:0] wd, rdat, q;
  logic [3:0] be;
  bit to;
  int num_errors = 0;
  int samples_checked = 0;
  always #12.5 clk = ~clk;
  fru_ieee_remainder_unit fru_ieee_remainder_unit_inst (.I_CORE_CLK(clk), .I_RESET_N(rst_n),
    .I_AVS_ADDRESS(addr), .I_AVS_READ(rd_en), .I_AVS_WRITE(wr_en), .I_AVS_WRITEDATA(wd),
    .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wrq), .O_BUSY(busy));
  fru_host_model fru_host_model_inst (.i_clk(clk), .i_waitreq(wrq), .i_rdata(rdat),
    .o_addr(addr), .o_read(rd_en), .o_write(wr_en), .o_wdata(wd), .o_be(be));
  task automatic end_sim();
    $display("checked %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic xf(input bit w, input logic [7:0] a, input logic [31:0] d);
    fru_host_model_inst.xfer(w, a, d, q, to);
    if (to) begin
      num_errors++;
      $display("[FAIL] t=%0t no answer got=%h exp=%h", $time, q, d);
      end_sim();
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    xf(1'b0, a, 32'h0);
    samples_checked++;
    if ((q & m) !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, q & m, e);
    end
  endtask
  task automatic setfp(input int n, input logic [63:0] x);
    xf(1'b1, 8'(8'h80 + n * 16), x[63:32]);
    xf(1'b1, 8'(8'h84 + n * 16), x[31:0]);
    xf(1'b1, 8'(8'h88 + n * 16), 32'h0);
  endtask
  // integer magnitude to extended words 0 and 1
  function automatic logic [63:0] xw(input int a, input bit s);
    int m;
    m = 31;
    if (a == 0)
      return {s, 63'h0};
    while (a[m] == 1'b0)
      m--;
    return {s, 15'(16383 + m), 16'h0, 32'(a) << (31 - m)};
  endfunction
  task automatic sp(input logic [63:0] dx, input logic [63:0] sx, input logic [31:0] est,
      input logic [31:0] ew, input logic [31:0] em, input logic [31:0] ew1);
    setfp(1, dx);
    setfp(2, sx);
    xf(1'b1, fru_pkg::ADDR_CMD, 32'hf20008a5);
    rc(fru_pkg::ADDR_STATUS, est, 32'h0000ff07);
    rc(8'h90, ew, em);
    rc(8'h94, ew1, '1);
  endtask
  initial begin
    int dv, sv, dm, am, qn, rr, k;
    logic [63:0] x;
    logic [2:0] fmt;
    logic [5:0] ea;
    logic [31:0] w0;
    int cd[4] = '{7, -7, 5, 100};
    int cs[4] = '{2, 2, -2, -7};
    logic [31:0] bad[6] = '{32'hf2800000, 32'hf2810000, 32'hf20840a5, 32'hf20054a5,
      32'hf23d40a5, 32'hf23c4ca5};
    logic [31:0] bst[6] = '{0, 2, 2, 2, 2, 4};
    void'($urandom(79));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rc(fru_pkg::ADDR_STATUS, 32'h0, '1);
    rc(fru_pkg::ADDR_CTRL, 32'h0, '1);
    rc(8'h40, 32'h0, '1);
    $display("reset test done");
    // corners first, then random operands
    for (int i = 0; i < 20; i++) begin
      if (i < 4) begin
        dv = cd[i];
        sv = cs[i];
      end else begin
        dm = int'($urandom_range(200, 1));
        dv = $urandom_range(1) ? -dm : dm;
        sv = int'($urandom_range(15, 1));
        if ($urandom_range(1))
          sv = -sv;
      end
      dm = dv < 0 ? -dv : dv;
      am = sv < 0 ? -sv : sv;
      qn = dm / am;
      rr = dm % am;
      // nearest, ties to even; truncation would differ here
      if (2 * rr > am || (2 * rr == am && qn % 2 == 1))
        qn++;
      rr = dm - qn * am;
      setfp(1, xw(dm, dv < 0));
      if (i < 4) begin
        setfp(2, xw(am, sv < 0));
        xf(1'b1, fru_pkg::ADDR_CMD, 32'hf20008a5);
      end else begin
        k = int'($urandom_range(4));
        fmt = k == 0 ? fru_pkg::FMT_LONG : k == 1 ? fru_pkg::FMT_WORD : k == 2 ? fru_pkg::FMT_BYTE
          : k == 3 ? fru_pkg::FMT_SINGLE : fru_pkg::FMT_DOUBLE;
        // single and double words built from the extended image of the modulus
        x = xw(am, sv < 0);
        w0 = $urandom;
        w0 = k == 0 ? 32'(sv) : k == 1 ? {w0[31:16], 16'(sv)} : k == 2 ? {w0[31:8], 8'(sv)}
          : k == 3 ? {x[63], 8'(x[62:48] - fru_pkg::SGL_ADJ), x[30:8]}
          : {x[63], 11'(x[62:48] - fru_pkg::DBL_ADJ), x[30:11]};
        // data register direct is not allowed for double
        ea = ($urandom_range(1) == 1 && k != 4) ? 6'h00 : 6'h3c;
        xf(1'b1, fru_pkg::ADDR_OPND0, w0);
        xf(1'b1, fru_pkg::ADDR_CMD, {10'h3c8, ea, 3'h2, fmt, 10'h0a5});
      end
      x = xw(rr < 0 ? -rr : rr, (dv < 0) ^ (rr < 0));
      rc(fru_pkg::ADDR_STATUS, {8'h0, (dv < 0) ^ (sv < 0), 7'(qn), 16'h0}, '1);
      rc(8'h90, x[63:32], '1);
      rc(8'h94, x[31:0], '1);
    end
    $display("remainder test done");
    sp(64'h40010000e0000000, 64'h0, 32'h2000, 32'h7fff0000, 32'h7fff0000, '1);
    sp(64'h7fff000000000000, 64'h4000000080000000, 32'h2000, 32'h7fff0000,
      32'h7fff0000, '1);
    sp(64'h40010000e0000000, 64'h7fff000000000000, 32'h0, 32'h40010000, '1,
      32'he0000000);
    // single precision: the returned old value loses its low bits and flags inexact
    xf(1'b1, fru_pkg::ADDR_CTRL, 32'h1);
    rc(fru_pkg::ADDR_CTRL, 32'h1, '1);
    sp(64'h40010000800000c0, 64'h7fff000000000000, 32'h200, 32'h40010000, '1,
      32'h80000100);
    xf(1'b1, fru_pkg::ADDR_CTRL, 32'h0);
    sp(64'h8000000000000000, 64'h4000000080000000, 32'h0, 32'h80000000, '1, 32'h0);
    $display("special test done");
    for (int i = 0; i < 6; i++) begin
      xf(1'b1, fru_pkg::ADDR_CMD, bad[i]);
      rc(fru_pkg::ADDR_STATUS, bst[i], 32'h6);
    end
    // another coprocessor's command leaves the registers alone
    setfp(1, 64'h40010000e0000000);
    xf(1'b1, fru_pkg::ADDR_CMD, 32'hf40008a5);
    rc(8'h90, 32'h40010000, '1);
    $display("decode test done");
    end_sim();
  end
endmodule
`default_nettype wire
